/* File: cpsl_top.v */
// Position output, teach and switching logic with AXI4-Lite registers
`timescale 1ns/100ps
`include "cpsl_consts.vh"
module cpsl_top #(
   parameter WIN_CYCLES = `CPSL_CLK_HZ / 1000000 * `CPSL_WIN_US
) (
   input wire i_clk_sys, // System clock, 25 MHz
   input wire i_reset, // Synchronous reset, active high
   input wire i_ce, // Clock enable, freezes all state when low
   input wire signed [15:0] i_lin_pos, // Linearized position, digits
   input wire i_field_ok, // Field strength sufficient
   input wire [7:0] s_axi_awaddr, // Write address
   input wire s_axi_awvalid, // Write address valid
   output reg s_axi_awready, // Write address ready
   input wire [31:0] s_axi_wdata, // Write data
   input wire [3:0] s_axi_wstrb, // Write byte strobes
   input wire s_axi_wvalid, // Write data valid
   output reg s_axi_wready, // Write data ready
   output reg [1:0] s_axi_bresp, // Write response
   output reg s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   input wire [7:0] s_axi_araddr, // Read address
   input wire s_axi_arvalid, // Read address valid
   output reg s_axi_arready, // Read address ready
   output reg [31:0] s_axi_rdata, // Read data
   output reg [1:0] s_axi_rresp, // Read response
   output reg s_axi_rvalid, // Read data valid
   input wire s_axi_rready, // Read data ready
   output reg signed [15:0] o_pos_code, // Position code
   output wire o_switch_output_one, // Switching output one
   output wire o_switch_output_two, // Switching output two
   output wire o_switch_output_three // Switching output three
);
   localparam SPEED_DIGITS = `CPSL_SPEED_UM_PER_S / `CPSL_UM_PER_DIGIT * `CPSL_WIN_US / 1000000;

   function [16:0] absdiff;
      input signed [15:0] a;
      input signed [15:0] b;
      reg signed [16:0] d;
      begin
         d = {a[15], a} - {b[15], b};
         absdiff = d[16] ? (17'd0 - d) : d;
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction

   // ****************************************
   // Registers and state
   // ****************************************
   reg dyn_mode;
   reg inner_grip;
   reg [2:0] width_mm;
   reg [15:0] hyst;
   reg learn_active;
   reg [1:0] lcnt;
   reg signed [15:0] lrn [0:2];
   reg signed [15:0] pt [0:2];
   reg [2:0] pt_def;
   reg [2:0] pt_dyn;
   reg pos_ok;
   reg [2:0] teach_req;
   reg lstart_req;
   reg lfinish_req;
   wire moving;
   wire still;
   wire signed [15:0] still_pos;
   wire [15:0] half = {13'h0, width_mm} * `CPSL_HALF_PER_MM;
   wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire [31:0] ctrl_rd = {30'h0, inner_grip, dyn_mode};
   wire [31:0] ctrl_new = merge(ctrl_rd, s_axi_wdata, s_axi_wstrb);
   wire [31:0] hyst_new = merge({16'h0, hyst}, s_axi_wdata, s_axi_wstrb);
   wire [2:0] sw_state = {o_switch_output_three, o_switch_output_two, o_switch_output_one};
   integer i;

   // ****************************************
   // Position code
   // ****************************************
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_pos_code <= 16'sh0;
         pos_ok <= 1'b0;
      end else if (i_ce) begin
         if (!i_field_ok) begin
            o_pos_code <= `CPSL_POS_WEAK;
            pos_ok <= 1'b0;
         end else if (i_lin_pos > `CPSL_POS_SPAN) begin
            o_pos_code <= `CPSL_POS_SAT_HI;
            pos_ok <= 1'b0;
         end else if (i_lin_pos < -`CPSL_POS_SPAN) begin
            o_pos_code <= `CPSL_POS_SAT_LO;
            pos_ok <= 1'b0;
         end else begin
            o_pos_code <= i_lin_pos;
            pos_ok <= 1'b1;
         end
      end
   end

   // ****************************************
   // Motion detection
   // ****************************************
   cpsl_motion #(
      .WIN_CYCLES(WIN_CYCLES),
      .SPEED_DIGITS(SPEED_DIGITS)
   ) u_motion (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_pos(o_pos_code),
      .i_pos_ok(pos_ok),
      .o_moving(moving),
      .o_still(still),
      .o_still_pos(still_pos)
   );

   // ****************************************
   // Teach, learning and tracking
   // ****************************************
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         learn_active <= 1'b0;
         lcnt <= 2'd0;
         pt_def <= 3'b000;
         pt_dyn <= 3'b000;
         for (i = 0; i < 3; i = i + 1) begin
            lrn[i] <= 16'sh0;
            pt[i] <= 16'sh0;
         end
      end else if (i_ce) begin
         if (lstart_req && dyn_mode) begin
            learn_active <= 1'b1;
            lcnt <= 2'd0;
         end else if (learn_active) begin
            // learning fed only by post-motion standstills
            if (still && lcnt < 2'd3 &&
                (lcnt < 2'd1 || absdiff(still_pos, lrn[0]) > {1'b0, half}) &&
                (lcnt < 2'd2 || absdiff(still_pos, lrn[1]) > {1'b0, half})) begin
               lrn[lcnt] <= still_pos;
               lcnt <= lcnt + 2'd1;
            end
            if (lfinish_req || lcnt == 2'd3) begin
               learn_active <= 1'b0;
               if (lcnt == 2'd2) begin
                  pt[0] <= (lrn[0] < lrn[1]) ? lrn[0] : lrn[1];
                  pt[1] <= (lrn[0] < lrn[1]) ? lrn[1] : lrn[0];
                  pt_def <= 3'b011;
                  pt_dyn <= 3'b011;
               end else if (lcnt == 2'd3) begin
                  pt[0] <= lrn[0];
                  if (absdiff(lrn[1], lrn[0]) < absdiff(lrn[2], lrn[0])) begin
                     pt[1] <= lrn[1];
                     pt[2] <= lrn[2];
                  end else begin
                     pt[1] <= lrn[2];
                     pt[2] <= lrn[1];
                  end
                  pt_def <= 3'b111;
                  pt_dyn <= 3'b111;
               end
            end
         end else begin
            for (i = 0; i < 3; i = i + 1) begin
               if (teach_req[i] && pos_ok) begin
                  pt[i] <= o_pos_code;
                  pt_def[i] <= 1'b1;
                  pt_dyn[i] <= 1'b0;
               end else if (still && dyn_mode && pt_dyn[i] && pt_def[i] &&
                            absdiff(still_pos, pt[i]) <= {1'b0, half}) begin
                  pt[i] <= still_pos;
               end
            end
         end
      end
   end

   // ****************************************
   // Switching outputs
   // ****************************************
   cpsl_window u_win0 (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_pos(o_pos_code),
      .i_pos_ok(pos_ok),
      .i_center(pt[0]),
      .i_defined(pt_def[0]),
      .i_half(half),
      .i_hyst(hyst),
      .o_on(o_switch_output_one)
   );
   cpsl_window u_win1 (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_pos(o_pos_code),
      .i_pos_ok(pos_ok),
      .i_center(pt[1]),
      .i_defined(pt_def[1]),
      .i_half(half),
      .i_hyst(hyst),
      .o_on(o_switch_output_two)
   );
   cpsl_window u_win2 (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_pos(o_pos_code),
      .i_pos_ok(pos_ok),
      .i_center(pt[2]),
      .i_defined(pt_def[2]),
      .i_half(half),
      .i_hyst(hyst),
      .o_on(o_switch_output_three)
   );

   // ****************************************
   // AXI4-Lite write path
   // ****************************************
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CPSL_RESP_OKAY;
         dyn_mode <= 1'b0;
         inner_grip <= 1'b0;
         width_mm <= `CPSL_WIDTH_DEF;
         hyst <= `CPSL_HYST_DEF;
         teach_req <= 3'b000;
         lstart_req <= 1'b0;
         lfinish_req <= 1'b0;
      end else if (i_ce) begin
         teach_req <= 3'b000;
         lstart_req <= 1'b0;
         lfinish_req <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `CPSL_RESP_OKAY;
            case (s_axi_awaddr)
               `CPSL_REG_CTRL: begin
                  dyn_mode <= ctrl_new[`CPSL_CTRL_DYN];
                  inner_grip <= ctrl_new[`CPSL_CTRL_INNER];
                  lstart_req <= s_axi_wstrb[0] & s_axi_wdata[`CPSL_CTRL_LSTART];
                  lfinish_req <= s_axi_wstrb[0] & s_axi_wdata[`CPSL_CTRL_LFINISH];
               end
               `CPSL_REG_TEACH: begin
                  teach_req <= s_axi_wdata[2:0] & {3{s_axi_wstrb[0]}};
               end
               `CPSL_REG_WIDTH: begin
                  if (s_axi_wstrb[0] && s_axi_wdata[7:0] >= {5'h0, `CPSL_WIDTH_MIN} &&
                      s_axi_wdata[7:0] <= {5'h0, `CPSL_WIDTH_MAX}) begin
                     width_mm <= s_axi_wdata[2:0];
                  end
               end
               `CPSL_REG_HYST: begin
                  hyst <= hyst_new[15:0];
               end
               `CPSL_REG_POS, `CPSL_REG_STATUS, `CPSL_REG_PT0, `CPSL_REG_PT1, `CPSL_REG_PT2: begin
                  s_axi_bresp <= `CPSL_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `CPSL_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // ****************************************
   // AXI4-Lite read path
   // ****************************************
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `CPSL_RESP_OKAY;
      end else if (i_ce) begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CPSL_RESP_OKAY;
            case (s_axi_araddr)
               `CPSL_REG_CTRL: s_axi_rdata <= ctrl_rd;
               `CPSL_REG_TEACH: s_axi_rdata <= 32'h0;
               `CPSL_REG_WIDTH: s_axi_rdata <= {29'h0, width_mm};
               `CPSL_REG_HYST: s_axi_rdata <= {16'h0, hyst};
               `CPSL_REG_POS: s_axi_rdata <= {{16{o_pos_code[15]}}, o_pos_code};
               `CPSL_REG_STATUS: begin
                  s_axi_rdata <= {23'h0, pos_ok, moving, lcnt, learn_active, pt_dyn[0], sw_state};
               end
               `CPSL_REG_PT0: s_axi_rdata <= {{16{pt[0][15]}}, pt[0]};
               `CPSL_REG_PT1: s_axi_rdata <= {{16{pt[1][15]}}, pt[1]};
               `CPSL_REG_PT2: s_axi_rdata <= {{16{pt[2][15]}}, pt[2]};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= `CPSL_RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule // cpsl_top

/* File: cpsl_consts.vh */
// Constants for the cylinder position and switching-point logic
`ifndef CPSL_CONSTS_VH
`define CPSL_CONSTS_VH
// ****************************************
// Position codes
// ****************************************
`define CPSL_POS_SPAN 16'sd2500
`define CPSL_POS_SAT_HI 16'sd32760
`define CPSL_POS_SAT_LO -16'sd32760
`define CPSL_POS_WEAK 16'sd32764
// ****************************************
// Window and hysteresis
// ****************************************
`define CPSL_WIDTH_DEF 3'd2
`define CPSL_WIDTH_MIN 3'd1
`define CPSL_WIDTH_MAX 3'd5
`define CPSL_HALF_PER_MM 16'd50
`define CPSL_HYST_DEF 16'd20
// ****************************************
// Motion timing
// ****************************************
`define CPSL_CLK_HZ 25000000
`define CPSL_WIN_US 10000
`define CPSL_SPEED_UM_PER_S 25000
`define CPSL_UM_PER_DIGIT 10
`define CPSL_STILL_DIGITS 17'd2
// ****************************************
// AXI4-Lite register map (byte addresses)
// ****************************************
`define CPSL_REG_CTRL 8'h00
`define CPSL_REG_TEACH 8'h04
`define CPSL_REG_WIDTH 8'h08
`define CPSL_REG_HYST 8'h0c
`define CPSL_REG_POS 8'h10
`define CPSL_REG_STATUS 8'h14
`define CPSL_REG_PT0 8'h18
`define CPSL_REG_PT1 8'h1c
`define CPSL_REG_PT2 8'h20
`define CPSL_CTRL_DYN 0
`define CPSL_CTRL_INNER 1
`define CPSL_CTRL_LSTART 2
`define CPSL_CTRL_LFINISH 3
`define CPSL_RESP_OKAY 2'b00
`define CPSL_RESP_SLVERR 2'b10
`endif

/* File: cpsl_motion.v */
// Speed and standstill detector over fixed sample windows
`timescale 1ns/100ps
module cpsl_motion #(
   parameter WIN_CYCLES = 250000,
   parameter SPEED_DIGITS = 25
) (
   input wire i_clk_sys, // System clock
   input wire i_reset, // Synchronous reset, active high
   input wire i_ce, // Clock enable
   input wire signed [15:0] i_pos, // Position in digits
   input wire i_pos_ok, // Position is in range
   output reg o_moving, // Speed above threshold
   output reg o_still, // Standstill after motion, pulse
   output reg signed [15:0] o_still_pos // Standstill position
);
`include "cpsl_consts.vh"
   reg [31:0] cnt;
   reg signed [15:0] last;
   reg armed;
   wire signed [16:0] delta = {i_pos[15], i_pos} - {last[15], last};
   wire [16:0] mag = delta[16] ? (17'd0 - delta) : delta;
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         cnt <= 32'h0;
         last <= 16'sh0;
         armed <= 1'b0;
         o_moving <= 1'b0;
         o_still <= 1'b0;
         o_still_pos <= 16'sh0;
      end else if (i_ce) begin
         o_still <= 1'b0;
         if (cnt >= WIN_CYCLES - 1) begin
            cnt <= 32'h0;
            last <= i_pos;
            o_moving <= i_pos_ok && (mag > SPEED_DIGITS);
            if (i_pos_ok && mag > SPEED_DIGITS) begin
               armed <= 1'b1;
            end else if (armed && i_pos_ok && mag <= `CPSL_STILL_DIGITS) begin
               armed <= 1'b0;
               o_still <= 1'b1;
               o_still_pos <= i_pos;
            end
         end else begin
            cnt <= cnt + 32'h1;
         end
      end
   end
endmodule // cpsl_motion

/* File: cpsl_window.v */
// One switching output with window and hysteresis
`timescale 1ns/100ps
module cpsl_window (
   input wire i_clk_sys, // System clock
   input wire i_reset, // Synchronous reset, active high
   input wire i_ce, // Clock enable
   input wire signed [15:0] i_pos, // Position in digits
   input wire i_pos_ok, // Position is valid
   input wire signed [15:0] i_center, // Window centre
   input wire i_defined, // Point is defined
   input wire [15:0] i_half, // Half window width in digits
   input wire [15:0] i_hyst, // Hysteresis in digits
   output reg o_on // Switching state
);
   wire signed [16:0] d = {i_pos[15], i_pos} - {i_center[15], i_center};
   wire [16:0] mag = d[16] ? (17'd0 - d) : d;
   always @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_on <= 1'b0;
      end else if (i_ce) begin
         if (!i_defined || !i_pos_ok) begin
            o_on <= 1'b0;
         end else if (mag <= {1'b0, i_half}) begin
            o_on <= 1'b1;
         end else if (mag > {1'b0, i_half} + {1'b0, i_hyst}) begin
            o_on <= 1'b0;
         end
      end
   end
endmodule // cpsl_window

/* File: cpsl_sva.sv */
// Concurrent checks on the position and switching block
`timescale 1ns/100ps
`include "cpsl_consts.vh"
module cpsl_sva (
   input wire i_clk_sys, // Clock
   input wire i_reset, // Reset
   input wire i_ce, // Enable
   input wire signed [15:0] i_lin_pos, // Position in
   input wire i_field_ok, // Field ok
   input wire s_axi_awready, // Aw ready
   input wire s_axi_wready, // W ready
   input wire [1:0] s_axi_bresp, // B resp
   input wire s_axi_bvalid, // B valid
   input wire s_axi_bready, // B ready
   input wire s_axi_arready, // Ar ready
   input wire [31:0] s_axi_rdata, // R data
   input wire s_axi_rvalid, // R valid
   input wire s_axi_rready, // R ready
   input wire signed [15:0] o_pos_code, // Code
   input wire o_switch_output_one, // Out one
   input wire o_switch_output_two, // Out two
   input wire o_switch_output_three // Out three
);
   wire [2:0] sw = {o_switch_output_three, o_switch_output_two, o_switch_output_one};
   wire code_bad = o_pos_code > `CPSL_POS_SPAN || o_pos_code < -`CPSL_POS_SPAN;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   chk_pos_span: assert property (i_ce && i_field_ok && i_lin_pos <= `CPSL_POS_SPAN
      && i_lin_pos >= -`CPSL_POS_SPAN |=> o_pos_code == $past(i_lin_pos)) else $error("code differs from input");
   chk_sat_high: assert property (i_ce && i_field_ok && i_lin_pos > `CPSL_POS_SPAN
      |=> o_pos_code == `CPSL_POS_SAT_HI) else $error("high saturation code missing");
   chk_sat_low: assert property (i_ce && i_field_ok && i_lin_pos < -`CPSL_POS_SPAN
      |=> o_pos_code == `CPSL_POS_SAT_LO) else $error("low saturation code missing");
   chk_weak_field: assert property (i_ce && !i_field_ok |=> o_pos_code == `CPSL_POS_WEAK)
      else $error("weak field code missing");
   chk_sw_invalid: assert property (i_ce && code_bad |=> sw == 3'b000)
      else $error("switch on with invalid code");
   chk_ce_freeze: assert property (!i_ce |=> $stable(o_pos_code) && $stable(sw))
      else $error("outputs moved while disabled");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_w_answer: assert property (i_ce && s_axi_awready && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   chk_r_answer: assert property (i_ce && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   cov_sat_high: cover property (o_pos_code == `CPSL_POS_SAT_HI);
   cov_sw_on: cover property ($rose(o_switch_output_one));
   cov_mid_on: cover property (sw == 3'b010);
   cov_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule // cpsl_sva
bind cpsl_top cpsl_sva u_sva (.i_clk_sys, .i_reset, .i_ce, .i_lin_pos, .i_field_ok, .s_axi_awready,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .o_pos_code, .o_switch_output_one, .o_switch_output_two, .o_switch_output_three);

/* File: cpsl_master.sv */
// Register bus master model standing in for the position reader
`timescale 1ns/100ps
module cpsl_master (
   input wire i_clk_sys, // Clock
   input wire i_slow, // Late response ready
   output reg [7:0] s_axi_awaddr = 8'h0, // Aw addr
   output reg s_axi_awvalid = 1'b0, // Aw valid
   input wire s_axi_awready, // Aw ready
   output reg [31:0] s_axi_wdata = 32'h0, // W data
   output reg [3:0] s_axi_wstrb = 4'hf, // W strobes
   output reg s_axi_wvalid = 1'b0, // W valid
   input wire s_axi_wready, // W ready
   input wire [1:0] s_axi_bresp, // B resp
   input wire s_axi_bvalid, // B valid
   output reg s_axi_bready = 1'b0, // B ready
   output reg [7:0] s_axi_araddr = 8'h0, // Ar addr
   output reg s_axi_arvalid = 1'b0, // Ar valid
   input wire s_axi_arready, // Ar ready
   input wire [31:0] s_axi_rdata, // R data
   input wire [1:0] s_axi_rresp, // R resp
   input wire s_axi_rvalid, // R valid
   output reg s_axi_rready = 1'b0, // R ready
   output reg o_done = 1'b0, // Result pulse
   output reg [33:0] o_result = 34'h0, // Resp and data
   output reg o_hang = 1'b0 // Wait ran out
);
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic pa;
      logic pw;
      int n;
      begin
         pa = 1'b1;
         pw = wr;
         n = 0;
         @(posedge i_clk_sys);
         s_axi_awaddr <= a;
         s_axi_araddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= wr;
         s_axi_wvalid <= wr;
         s_axi_arvalid <= !wr;
         while ((pa || pw) && n < 200) begin
            @(posedge i_clk_sys);
            n++;
            if (wr ? s_axi_awready : s_axi_arready) begin
               pa = 1'b0;
               s_axi_awvalid <= 1'b0;
               s_axi_arvalid <= 1'b0;
            end
            if (s_axi_wready) begin
               pw = 1'b0;
               s_axi_wvalid <= 1'b0;
            end
         end
         if (i_slow) repeat ($urandom_range(3)) @(posedge i_clk_sys);
         s_axi_bready <= wr;
         s_axi_rready <= !wr;
         do begin
            @(posedge i_clk_sys);
            n++;
         end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 200);
         s_axi_bready <= 1'b0;
         s_axi_rready <= 1'b0;
         o_result <= wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
         o_done <= 1'b1;
         o_hang <= n >= 200;
         @(posedge i_clk_sys);
         o_done <= 1'b0;
      end
   endtask
endmodule // cpsl_master

/* File: cylinder_position_switch_logic_bench.sv */
// Self-checking bench for the position and switching block
`timescale 1ns/100ps
`include "cpsl_consts.vh"
module cylinder_position_switch_logic_bench;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic i_ce = 1'b1;
   logic signed [15:0] i_lin_pos = 16'sh0;
   logic i_field_ok = 1'b1;
   logic i_slow = 1'b0;
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, o_done, o_hang;
   wire [33:0] o_result;
   wire signed [15:0] o_pos_code;
   wire o_switch_output_one, o_switch_output_two, o_switch_output_three;
   logic [67:0] notes[$];
   logic [67:0] note;
   logic signed [15:0] bnd[5] = '{-16'sd2501, -16'sd2500, 16'sd0, 16'sd2500, 16'sd2501};
   logic signed [15:0] hp[5] = '{16'sd1100, 16'sd1115, 16'sd1121, 16'sd1115, 16'sd1100};
   logic [4:0] hs = 5'b10011;
   int n_mismatch = 0;
   int checks_done = 0;
   always #20 i_clk_sys = ~i_clk_sys;
   cpsl_top #(.WIN_CYCLES(50)) dut (.i_clk_sys, .i_reset, .i_ce, .i_lin_pos, .i_field_ok, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .o_pos_code, .o_switch_output_one, .o_switch_output_two,
      .o_switch_output_three);
   cpsl_master u_mst (.i_clk_sys, .i_slow, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_done,
      .o_result, .o_hang);
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      begin
         checks_done++;
         if (seen !== want) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
         end
      end
   endtask
   task automatic complete_run;
      if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Oldest note is matched against each bus result
   always @(posedge i_clk_sys) begin
      if (o_hang === 1'b1) begin
         n_mismatch++;
         complete_run;
      end else if (o_done === 1'b1) begin
         note = notes.pop_front();
         check(o_result & note[67:34], note[33:0]);
      end
   end
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [67:0] n);
      begin
         notes.push_back(n);
         u_mst.xfer(wr, a, d);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d, {2'b11, 66'h0});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] w, input logic [31:0] m);
      acc(1'b0, a, 32'h0, {2'b11, m, 2'b00, w});
   endtask
   function automatic logic [31:0] code(input logic signed [15:0] p, input logic f);
      logic signed [15:0] c;
      begin
         c = !f ? `CPSL_POS_WEAK : p > `CPSL_POS_SPAN ? `CPSL_POS_SAT_HI : p < -`CPSL_POS_SPAN ? `CPSL_POS_SAT_LO : p;
         code = {{16{c[15]}}, c};
      end
   endfunction
   // Enable drops briefly with every position change
   task automatic setpos(input logic signed [15:0] p, input logic f, input int cyc);
      begin
         @(posedge i_clk_sys);
         i_lin_pos <= p;
         i_field_ok <= f;
         i_ce <= 1'b0;
         repeat ($urandom_range(3, 1)) @(posedge i_clk_sys);
         i_ce <= 1'b1;
         repeat (cyc) @(posedge i_clk_sys);
      end
   endtask
   initial begin
      int i;
      logic [31:0] e;
      logic signed [15:0] p;
      void'($urandom(32'h5fd0));
      repeat (12) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      rd(`CPSL_REG_CTRL, 32'h0, 32'hffffffff);
      rd(`CPSL_REG_HYST, 32'd20, 32'hffffffff);
      acc(1'b0, 8'h40, 32'h0, {34'h3ffffffff, `CPSL_RESP_SLVERR, 32'h0});
      acc(1'b1, 8'h24, 32'h5a, {2'b11, 32'h0, `CPSL_RESP_SLVERR, 32'h0});
      e = 32'd2;
      for (i = 0; i < 7; i++) begin
         rd(`CPSL_REG_WIDTH, e, 32'hffffffff);
         wr(`CPSL_REG_WIDTH, 32'(i));
         if (i >= 1 && i <= 5) e = 32'(i);
      end
      wr(`CPSL_REG_WIDTH, 32'd2);
      for (i = 0; i < 9; i++) begin
         p = i < 5 ? bnd[i] : i < 7 ? 16'($urandom_range(5000)) - 16'sd2500 : 16'($urandom);
         setpos(p, i != 8, 4);
         rd(`CPSL_REG_POS, code(p, i != 8), 32'hffffffff);
      end
      wr(`CPSL_REG_POS, 32'h1234);
      rd(`CPSL_REG_POS, code(p, 1'b0), 32'hffffffff);
      i_slow <= 1'b1;
      setpos(16'sd1000, 1'b1, 200);
      wr(`CPSL_REG_TEACH, 32'h1);
      for (i = 0; i < 5; i++) begin
         setpos(hp[i], 1'b1, 4);
         rd(`CPSL_REG_STATUS, {31'h0, hs[i]}, 32'h1);
      end
      setpos(16'sd1050, 1'b1, 200);
      rd(`CPSL_REG_PT0, 32'd1000, 32'hffffffff);
      wr(`CPSL_REG_CTRL, 32'h5);
      setpos(16'sd800, 1'b1, 200);
      setpos(-16'sd900, 1'b1, 200);
      wr(`CPSL_REG_CTRL, 32'h9);
      rd(`CPSL_REG_PT0, code(-16'sd900, 1'b1), 32'hffffffff);
      rd(`CPSL_REG_PT1, code(16'sd800, 1'b1), 32'hffffffff);
      rd(`CPSL_REG_STATUS, 32'h48, 32'h78);
      wr(`CPSL_REG_CTRL, 32'h5);
      for (i = 1; i <= 10; i++) setpos(-16'sd900 + 16'(20 * i), 1'b1, 60);
      rd(`CPSL_REG_STATUS, 32'h10, 32'hf0);
      wr(`CPSL_REG_CTRL, 32'h9);
      rd(`CPSL_REG_PT0, code(-16'sd900, 1'b1), 32'hffffffff);
      for (i = 0; i < 2; i++) begin
         wr(`CPSL_REG_CTRL, 32'h5 | 32'(i << 1));
         rd(`CPSL_REG_CTRL, 32'h1 | 32'(i << 1), 32'h3);
         setpos(16'sd0, 1'b1, 200);
         setpos(16'sd1500, 1'b1, 200);
         setpos(16'sd400, 1'b1, 200);
         rd(`CPSL_REG_PT0, 32'd0, 32'hffffffff);
         rd(`CPSL_REG_PT1, 32'd400, 32'hffffffff);
         rd(`CPSL_REG_PT2, 32'd1500, 32'hffffffff);
         rd(`CPSL_REG_STATUS, 32'h16a, 32'h17f);
      end
      wr(`CPSL_REG_TEACH, 32'h1);
      setpos(16'sd1500, 1'b1, 200);
      setpos(16'sd430, 1'b1, 200);
      rd(`CPSL_REG_PT0, 32'd400, 32'hffffffff);
      rd(`CPSL_REG_PT1, 32'd430, 32'hffffffff);
      rd(`CPSL_REG_STATUS, 32'h0, 32'h8);
      repeat (4) @(posedge i_clk_sys);
      complete_run;
   end
endmodule // cylinder_position_switch_logic_bench
